// file: periodic_timebase.sv
// Periodic timebase with one control register, event status/mask and APB access.
// Assumes pclk is the oscillator clock; mode inputs come from pclk logic, straps from pins.
//
// Our own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps

module periodic_timebase
  import timebase_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic wait_mode,
  input wire logic stop_mode,
  input wire logic extra_prescale_option,
  input wire logic osc_run_in_stop_option,
  output logic irq,
  output logic stop_wakeup
);

  // Straps arrive from pins, so both pass two flip-flops first.
  logic prescale_meta_reg;
  logic prescale_sync_reg;
  logic osc_stop_meta_reg;
  logic osc_stop_sync_reg;

  logic [2:0] period_tap_select_reg;
  logic period_irq_enable_reg;
  logic period_counter_enable_reg;
  logic period_pending_flag_reg;
  logic period_pending_flag_next;
  logic [EVT_WIDTH-1:0] evt_status_reg;
  logic [EVT_WIDTH-1:0] evt_status_next;
  logic [EVT_WIDTH-1:0] evt_mask_reg;
  logic [CHAIN_STAGES-1:0] count_reg;
  logic [CHAIN_STAGES-1:0] count_next;
  logic [PRESCALE_BITS-1:0] prescale_reg;
  logic [PRESCALE_BITS-1:0] prescale_next;
  logic [31:0] prdata_reg;
  timebase_state_type state_reg;
  timebase_state_type state_next;

  // Bus decode.
  wire logic low_power = wait_mode | stop_mode;
  wire logic hit_ctrl = (paddr == CTRL_OFFSET);
  wire logic hit_status = (paddr == EVT_STATUS_OFFSET);
  wire logic hit_mask = (paddr == EVT_MASK_OFFSET);
  wire logic hit_count = (paddr == COUNT_STATE_OFFSET);
  wire logic mapped = hit_ctrl | hit_status | hit_mask | hit_count;
  wire logic setup_phase = psel & ~penable;
  wire logic access_phase = psel & penable;
  wire logic access_ok = mapped & ~low_power;
  wire logic wr_ok = access_phase & pwrite & access_ok;
  wire logic wr_ctrl = wr_ok & hit_ctrl;
  wire logic wr_status = wr_ok & hit_status;
  wire logic wr_mask = wr_ok & hit_mask;
  wire logic ack_write = wr_ctrl & pwdata[ACK_BIT];

  // The counter is frozen in stop unless the oscillator keeps running there.
  wire logic chain_active = ~stop_mode | osc_stop_sync_reg;
  wire logic run_now = period_counter_enable_reg & chain_active;
  wire logic prescale_wrap = (prescale_reg == PRESCALE_BITS'(PRESCALE_DIV - 1));
  wire logic source_tick = run_now & (~prescale_sync_reg | prescale_wrap);

  // Tap decode: the event fires when the tap bit goes from zero to one.
  // Catching the rising half of the tap bit is why the first event comes at half the period.
  wire logic [3:0] tap_bit = TAP_BIT_TABLE[period_tap_select_reg];
  wire logic [CHAIN_STAGES-1:0] low_mask = (CHAIN_STAGES'(1) << tap_bit) - CHAIN_STAGES'(1);
  wire logic low_full = ((count_reg & low_mask) == low_mask);
  wire logic rollover = source_tick & low_full & ~count_reg[tap_bit];

  // Next-state logic.
  assign prescale_next = (run_now & prescale_sync_reg) ? prescale_reg + PRESCALE_BITS'(1) :
                         (period_counter_enable_reg ? prescale_reg : '0);
  assign count_next = ~period_counter_enable_reg ? '0 :
                      (source_tick ? count_reg + CHAIN_STAGES'(1) : count_reg);
  // Set wins over the acknowledge so that no event is lost.
  assign period_pending_flag_next = rollover ? 1'b1 :
                                    (ack_write ? 1'b0 : period_pending_flag_reg);
  wire logic [EVT_WIDTH-1:0] evt_set = {rollover & period_pending_flag_reg & ~ack_write,
                                        rollover};
  wire logic [EVT_WIDTH-1:0] evt_clr = wr_status ? pwdata[EVT_WIDTH-1:0] : '0;
  assign evt_status_next = evt_set | (evt_status_reg & ~evt_clr);
  assign state_next = ~period_counter_enable_reg ? ST_OFF : (chain_active ? ST_RUN : ST_HOLD);

  // Read multiplexer; the acknowledge position always reads zero.
  wire logic [31:0] ctrl_view = {24'h0000_00, period_pending_flag_reg, period_tap_select_reg,
                                 1'b0, period_irq_enable_reg, period_counter_enable_reg, 1'b0};
  wire logic [31:0] count_view = {13'h0000, state_reg, 1'b0, count_reg};
  wire logic [31:0] read_value = ~access_ok ? 32'h0000_0000 :
                                 hit_ctrl ? ctrl_view :
                                 hit_status ? {30'h0000_0000, evt_status_reg} :
                                 hit_mask ? {30'h0000_0000, evt_mask_reg} : count_view;

  // Zero-wait slave; read data is latched in the setup cycle.
  assign pready = 1'b1;
  assign pslverr = access_phase & ~access_ok;
  assign prdata = prdata_reg;
  assign irq = (period_pending_flag_reg & period_irq_enable_reg) |
               (|(evt_status_reg & evt_mask_reg));
  assign stop_wakeup = stop_mode & osc_stop_sync_reg & period_pending_flag_reg &
                       period_irq_enable_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prescale_meta_reg <= 1'b0;
      prescale_sync_reg <= 1'b0;
      osc_stop_meta_reg <= 1'b0;
      osc_stop_sync_reg <= 1'b0;
    end else begin
      prescale_meta_reg <= extra_prescale_option;
      prescale_sync_reg <= prescale_meta_reg;
      osc_stop_meta_reg <= osc_run_in_stop_option;
      osc_stop_sync_reg <= osc_stop_meta_reg;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      period_tap_select_reg <= TAP_RESET;
      period_irq_enable_reg <= IRQ_EN_RESET;
      period_counter_enable_reg <= CNT_EN_RESET;
      evt_mask_reg <= EVT_MASK_RESET;
    end else begin
      if (wr_ctrl) begin
        period_tap_select_reg <= pwdata[TAP_MSB:TAP_LSB];
        period_irq_enable_reg <= pwdata[IRQ_EN_BIT];
        period_counter_enable_reg <= pwdata[CNT_EN_BIT];
      end
      if (wr_mask) begin
        evt_mask_reg <= pwdata[EVT_WIDTH-1:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      period_pending_flag_reg <= 1'b0;
      evt_status_reg <= '0;
      count_reg <= '0;
      prescale_reg <= '0;
      state_reg <= ST_OFF;
      prdata_reg <= 32'h0000_0000;
    end else begin
      period_pending_flag_reg <= period_pending_flag_next;
      evt_status_reg <= evt_status_next;
      count_reg <= count_next;
      prescale_reg <= prescale_next;
      state_reg <= state_next;
      if (setup_phase) begin
        prdata_reg <= read_value;
      end
    end
  end

  a_flag_on_rollover: assert property (
    @(posedge pclk) disable iff (!presetn)
    rollover |=> period_pending_flag_reg)
    else $error("Pending flag not set after rollover.");

  a_irq_from_flag: assert property (
    @(posedge pclk) disable iff (!presetn)
    $rose(period_pending_flag_reg) && period_irq_enable_reg |-> irq)
    else $error("Interrupt not raised for an enabled pending flag.");

  a_period_tap_eight: assert property (
    @(posedge pclk) disable iff (!presetn)
    (rollover && period_tap_select_reg == 3'b111 && !prescale_sync_reg && !stop_mode)
    ##1 (run_now && period_tap_select_reg == 3'b111 && !prescale_sync_reg)[*8]
    |-> rollover)
    else $error("Tap code 7 did not give an eight cycle period.");

  a_prescale_gap: assert property (
    @(posedge pclk) disable iff (!presetn)
    (source_tick && prescale_sync_reg) |=> !source_tick [*8])
    else $error("Prescaled source ticked too soon.");

  a_off_chain_zero: assert property (
    @(posedge pclk) disable iff (!presetn)
    !period_counter_enable_reg |=> (count_reg == '0) && !rollover)
    else $error("Chain not held at zero while disabled.");

  a_first_half_period: assert property (
    @(posedge pclk) disable iff (!presetn)
    ($rose(period_counter_enable_reg) && period_tap_select_reg == 3'b111 &&
     !prescale_sync_reg && chain_active)
    ##1 (run_now && period_tap_select_reg == 3'b111 && !prescale_sync_reg)[*3]
    |-> rollover)
    else $error("First event after enabling not at half the period.");

  a_ack_clears_flag: assert property (
    @(posedge pclk) disable iff (!presetn)
    ack_write && !rollover |=> !period_pending_flag_reg)
    else $error("Acknowledge did not clear the pending flag.");

  a_ack_reads_zero: assert property (
    @(posedge pclk) disable iff (!presetn)
    access_phase && !pwrite && hit_ctrl |-> !prdata[ACK_BIT])
    else $error("Acknowledge bit read back as one.");

  a_set_beats_ack: assert property (
    @(posedge pclk) disable iff (!presetn)
    rollover && ack_write |=> period_pending_flag_reg)
    else $error("Rollover lost against a same cycle acknowledge.");

  a_stop_freezes_chain: assert property (
    @(posedge pclk) disable iff (!presetn)
    stop_mode && !osc_stop_sync_reg && period_counter_enable_reg |=> $stable(count_reg))
    else $error("Chain moved in stop without the oscillator option.");

  a_lowpower_blocks_bus: assert property (
    @(posedge pclk) disable iff (!presetn)
    access_phase && low_power && pwrite && hit_ctrl
    |-> pslverr ##1 $stable(period_irq_enable_reg) && $stable(period_counter_enable_reg))
    else $error("Control register written during a low power mode.");

  a_wait_keeps_running: assert property (
    @(posedge pclk) disable iff (!presetn)
    wait_mode && !stop_mode && period_counter_enable_reg && !prescale_sync_reg
    |=> count_reg == $past(count_reg) + CHAIN_STAGES'(1))
    else $error("Chain stopped counting in wait mode.");

  a_ack_zero_keeps: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_ctrl && !pwdata[ACK_BIT] && period_pending_flag_reg |=> period_pending_flag_reg)
    else $error("Writing zero to the acknowledge cleared the flag.");

  a_flag_only_by_roll: assert property (
    @(posedge pclk) disable iff (!presetn)
    !rollover && !period_pending_flag_reg |=> !period_pending_flag_reg)
    else $error("Pending flag set without a rollover.");

  a_irq_masked_off: assert property (
    @(posedge pclk) disable iff (!presetn)
    !period_irq_enable_reg && !(|(evt_status_reg & evt_mask_reg)) |-> !irq)
    else $error("Interrupt raised with the enable clear.");

  a_irq_enable_write: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_ctrl |=> period_irq_enable_reg == $past(pwdata[IRQ_EN_BIT]))
    else $error("Interrupt enable did not take the written value.");

  a_enable_write: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_ctrl |=> period_counter_enable_reg == $past(pwdata[CNT_EN_BIT]))
    else $error("Counter enable did not take the written value.");

  a_restart_zero: assert property (
    @(posedge pclk) disable iff (!presetn)
    $rose(period_counter_enable_reg) |-> count_reg == '0)
    else $error("Chain did not restart from zero.");

  a_run_counts: assert property (
    @(posedge pclk) disable iff (!presetn)
    run_now && !prescale_sync_reg && !wr_ctrl |=> count_reg == $past(count_reg) + CHAIN_STAGES'(1))
    else $error("Enabled chain did not count.");

  a_stop_freezes_pre: assert property (
    @(posedge pclk) disable iff (!presetn)
    stop_mode && !osc_stop_sync_reg && period_counter_enable_reg |=> $stable(prescale_reg))
    else $error("Prescaler moved in stop without the oscillator option.");

  a_wakeup_needs_irq: assert property (
    @(posedge pclk) disable iff (!presetn)
    stop_wakeup |-> irq && stop_mode && osc_stop_sync_reg)
    else $error("Wakeup raised without an enabled pending flag in stop.");

  a_wait_blocks_write: assert property (
    @(posedge pclk) disable iff (!presetn)
    access_phase && wait_mode && pwrite && hit_ctrl |=> $stable(period_tap_select_reg))
    else $error("Tap select written during wait mode.");

  a_lowpower_reads_zero: assert property (
    @(posedge pclk) disable iff (!presetn)
    setup_phase && low_power |=> prdata == 32'h0000_0000)
    else $error("Register data returned during a low power mode.");

  a_wait_flag_sets: assert property (
    @(posedge pclk) disable iff (!presetn)
    wait_mode && rollover |=> period_pending_flag_reg)
    else $error("Flag not set by a rollover in wait mode.");

  a_prescale_period: assert property (
    @(posedge pclk) disable iff (!presetn)
    run_now && prescale_sync_reg && prescale_reg == PRESCALE_BITS'(PRESCALE_DIV - 2) |=> prescale_wrap)
    else $error("Prescaler did not reach its wrap point.");

  a_direct_tick: assert property (
    @(posedge pclk) disable iff (!presetn)
    run_now && !prescale_sync_reg |-> source_tick)
    else $error("Unprescaled chain missed a source clock.");

  a_tap_zero_point: assert property (
    @(posedge pclk) disable iff (!presetn)
    rollover && period_tap_select_reg == 3'b000 |-> count_reg[13:0] == 14'h3FFF)
    else $error("Tap code 0 rolled over at the wrong count.");

  a_tap_three_point: assert property (
    @(posedge pclk) disable iff (!presetn)
    rollover && period_tap_select_reg == 3'b011 |-> count_reg[6:0] == 7'h3F)
    else $error("Tap code 3 rolled over at the wrong count.");

  a_status_set_wins: assert property (
    @(posedge pclk) disable iff (!presetn)
    rollover && wr_status && pwdata[EVT_ROLL_BIT] |=> evt_status_reg[EVT_ROLL_BIT])
    else $error("Rollover event lost against a same cycle clear.");

  a_overrun_marks: assert property (
    @(posedge pclk) disable iff (!presetn)
    rollover && period_pending_flag_reg && !ack_write |=> evt_status_reg[EVT_OVERRUN_BIT])
    else $error("Rollover on a pending flag not marked as overrun.");

  a_stop_errors: assert property (
    @(posedge pclk) disable iff (!presetn)
    access_phase && stop_mode |-> pslverr)
    else $error("Access in stop mode not refused.");

  a_hold_state: assert property (
    @(posedge pclk) disable iff (!presetn)
    period_counter_enable_reg && !chain_active |=> state_reg == ST_HOLD)
    else $error("Frozen chain not reported as held.");

endmodule : periodic_timebase

// file: periodic_timebase_bench.sv
// Self-checking bench for the periodic timebase, driven over APB.
// Assumes the register map and field layout of timebase_pkg; the APB task waits on pready.
`timescale 1ns/1ps
module periodic_timebase_bench;
  import timebase_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, wait_mode, stop_mode, er;
  logic extra_prescale_option, osc_run_in_stop_option, pready, pslverr, irq, stop_wakeup;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  int errors = 0, check_count = 0, cyc = 0, t0, t1, d;
  periodic_timebase DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .wait_mode(wait_mode), .stop_mode(stop_mode),
    .extra_prescale_option(extra_prescale_option),
    .osc_run_in_stop_option(osc_run_in_stop_option), .irq(irq), .stop_wakeup(stop_wakeup));
  initial begin
    pclk = 0;
    forever #12.5 pclk = ~pclk;
  end
  // The ceiling sits well above the longest tap sweep so a hung wait ends the run.
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 95000) begin
      errors++;
      conclude();
    end
  end
  function automatic int divider(input logic [2:0] tap, input logic pre);
    int base[8] = '{32768, 8192, 2048, 128, 64, 32, 16, 8};
    return pre ? base[tap] * PRESCALE_DIV : base[tap];
  endfunction : divider
  function automatic logic [31:0] ctrl(input logic [2:0] tap, input logic ie, en, ack);
    return ({29'h0, tap} << TAP_LSB) | ({31'h0, ie} << IRQ_EN_BIT)
      | ({31'h0, en} << CNT_EN_BIT) | ({31'h0, ack} << ACK_BIT);
  endfunction : ctrl
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] dat);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= dat;
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb
  task automatic wait_irq(input int lim);
    int n;
    n = 0;
    @(negedge pclk);
    while (irq !== 1'b1 && n < lim) begin
      @(negedge pclk);
      n++;
    end
    t1 = cyc;
  endtask : wait_irq
  task automatic period(input logic [2:0] tap, input logic pre);
    d = divider(tap, pre);
    apb(1, CTRL_OFFSET, ctrl(tap, 1, 0, 1));
    apb(1, CTRL_OFFSET, ctrl(tap, 1, 1, 0));
    t0 = cyc;
    wait_irq(d + 300);
    chk({31'h0, (t1 - t0 > d / 2 - 140) && (t1 - t0 < d / 2 + (pre ? 140 : 4))}, 1, "first");
    t0 = t1;
    apb(1, CTRL_OFFSET, ctrl(tap, 1, 1, 1));
    wait_irq(d + 10);
    chk(32'(t1 - t0), 32'(d), "period");
    apb(1, CTRL_OFFSET, ctrl(tap, 1, 0, 1));
    $display("tap %0d prescale %0d done", tap, pre);
  endtask : period
  task automatic conclude();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : conclude
  initial begin
    {presetn, psel, penable, pwrite, wait_mode, stop_mode, extra_prescale_option} = '0;
    osc_run_in_stop_option = 1;
    paddr = '0;
    pwdata = '0;
    void'($urandom(93));
    repeat (12) @(posedge pclk);
    presetn <= 1;
    apb(0, CTRL_OFFSET, 0);
    chk(rd, 32'h0, "ctrl reset");
    for (int i = 0; i < 8; i++) period(3'(i), 0);
    extra_prescale_option <= 1;
    period(3'(4 + $urandom % 4), 1);
    extra_prescale_option <= 0;
    apb(1, CTRL_OFFSET, ctrl(7, 0, 1, 0));
    repeat (30) @(negedge pclk);
    chk({31'h0, irq}, 0, "irq masked");
    apb(1, CTRL_OFFSET, ctrl(7, 0, 1, 0));
    apb(0, CTRL_OFFSET, 0);
    chk(rd, ctrl(7, 0, 1, 0) | 32'h0000_0080, "flag held, ack reads 0");
    apb(0, EVT_STATUS_OFFSET, 0);
    chk(rd, 32'h0000_0003, "rollover and overrun");
    d = $urandom;
    apb(1, EVT_MASK_OFFSET, d);
    apb(0, EVT_MASK_OFFSET, 0);
    chk(rd, d & 32'h0000_0003, "mask readback");
    apb(1, EVT_MASK_OFFSET, 32'h0000_0001);
    @(negedge pclk);
    chk({31'h0, irq}, 1, "event irq");
    apb(1, CTRL_OFFSET, ctrl(7, 0, 0, 1));
    apb(1, EVT_STATUS_OFFSET, 32'h0000_0003);
    apb(0, COUNT_STATE_OFFSET, 0);
    chk(rd & 32'h0007_7FFF, {13'h0, ST_OFF, 16'h0}, "chain cleared");
    chk({31'h0, irq}, 0, "events cleared");
    apb(0, 12'h010, 0);
    chk({er, rd[30:0]}, 32'h8000_0000, "unmapped refused");
    $display("flags and events done");
    apb(1, CTRL_OFFSET, ctrl(7, 1, 1, 0));
    wait_mode <= 1;
    apb(0, CTRL_OFFSET, 0);
    chk({er, rd[30:0]}, 32'h8000_0000, "wait refused");
    stop_mode <= 1;
    wait_irq(20);
    chk({30'h0, irq, stop_wakeup}, 32'h0000_0003, "wake from stop");
    apb(0, CTRL_OFFSET, 0);
    chk({31'h0, er}, 1, "stop refused");
    {wait_mode, stop_mode, osc_run_in_stop_option} <= 3'h0;
    apb(1, CTRL_OFFSET, ctrl(7, 1, 0, 1));
    apb(1, CTRL_OFFSET, ctrl(0, 1, 1, 1));
    apb(0, COUNT_STATE_OFFSET, 0);
    t0 = int'(rd[14:0]);
    stop_mode <= 1;
    repeat (200) @(posedge pclk);
    stop_mode <= 0;
    apb(0, COUNT_STATE_OFFSET, 0);
    chk({31'h0, int'(rd[14:0]) - t0 < 20}, 1, "frozen in stop");
    $display("low power done");
    conclude();
  end
endmodule : periodic_timebase_bench

// file: timebase_pkg.sv
// Constants, register map and field layout for the periodic timebase block.
// Assumes an APB master with 32-bit data and word-aligned register accesses.
package timebase_pkg;

  // Register byte offsets.
  localparam logic [11:0] CTRL_OFFSET = 12'h000;
  localparam logic [11:0] EVT_STATUS_OFFSET = 12'h004;
  localparam logic [11:0] EVT_MASK_OFFSET = 12'h008;
  localparam logic [11:0] COUNT_STATE_OFFSET = 12'h00C;

  // Field positions in timebase_control.
  localparam int FLAG_BIT = 7;
  localparam int TAP_LSB = 4;
  localparam int TAP_MSB = 6;
  localparam int ACK_BIT = 3;
  localparam int IRQ_EN_BIT = 2;
  localparam int CNT_EN_BIT = 1;

  // Event status and mask layout.
  localparam int EVT_ROLL_BIT = 0;
  localparam int EVT_OVERRUN_BIT = 1;
  localparam int EVT_WIDTH = 2;

  // Reset values.
  localparam logic [2:0] TAP_RESET = 3'h0;
  localparam logic IRQ_EN_RESET = 1'b0;
  localparam logic CNT_EN_RESET = 1'b0;
  localparam logic [1:0] EVT_MASK_RESET = 2'h0;

  // Counter chain geometry and the extra fixed prescaler.
  localparam int CHAIN_STAGES = 15;
  localparam int PRESCALE_DIV = 128;
  localparam int PRESCALE_BITS = 7;

  // Bit of the chain that marks each tap, indexed by tap code.
  // Codes 0 to 7 give dividers 32768, 8192, 2048, 128, 64, 32, 16, 8.
  localparam logic [7:0][3:0] TAP_BIT_TABLE = {
    4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'hA, 4'hC, 4'hE
  };

  typedef enum logic [2:0] {
    ST_OFF = 3'b001,
    ST_RUN = 3'b010,
    ST_HOLD = 3'b100
  } timebase_state_type;

endpackage : timebase_pkg
